// File: aux_irq_pkg.sv
// Constants, register map and carrier types of the auxiliary interrupt poll and pending block
package aux_irq_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;

  // ----------------------------------------------------------------
  // Register indices and byte addresses (byte address = index * 4)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_POLL = 8'hA4;
  localparam logic [7:0] IDX_PEND = 8'hA5;
  localparam logic [7:0] IDX_MASK = 8'hA6;
  localparam logic [7:0] IDX_STAT = 8'hA7;
  localparam logic [7:0] IDX_XCTL = 8'hD8;
  localparam logic [ADDR_W-1:0] ADDR_POLL = {2'h0, IDX_POLL, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_PEND = {2'h0, IDX_PEND, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_MASK = {2'h0, IDX_MASK, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_STAT = {2'h0, IDX_STAT, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_XCTL = {2'h0, IDX_XCTL, 2'h0};

  // ----------------------------------------------------------------
  // Source bit positions in poll, mask and status views
  // ----------------------------------------------------------------
  localparam int NUM_SRC = 8;
  localparam int SRC_DIG_LOW_V = 0;
  localparam int SRC_ANA_LOW_V = 1;
  localparam int SRC_SPI_RX_I2C = 2;
  localparam int SRC_SPI_TX = 3;
  localparam int SRC_MSEC = 4;
  localparam int SRC_ADC = 5;
  localparam int SRC_SUM = 6;
  localparam int SRC_SEC = 7;

  // ----------------------------------------------------------------
  // Control fields and reset values
  // ----------------------------------------------------------------
  localparam int POLL_READ_SELECT_BIT = 0;
  localparam int XCTL_AUX_EN_BIT = 4;
  localparam int PEND_W = 4;
  localparam logic [PEND_W-1:0] PEND_NONE = 4'h0;
  localparam logic [NUM_SRC-1:0] MASK_RST = 8'h00;
  localparam logic POLL_READ_SELECT_RST = 1'b0;
  localparam logic XCTL_AUX_EN_RST = 1'b0;
  localparam logic [15:0] AUX_VECTOR_ADDR = 16'h0033;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Carrier towards the core's interrupt logic
  // ----------------------------------------------------------------
  typedef struct packed {
    logic req;
    logic [PEND_W-1:0] index;
    logic [15:0] vector;
  } irq_out_s;

endpackage

// File: aux_interrupt_poll_pending.sv
// Auxiliary interrupt poll, mask, status and pending index with an AXI4-Lite register slave
//
// Overview of operation
// - With read-select at 1, the poll register reads raw sources and the mask register its mask.
// - With read-select at 0, the poll register reads the mask and the mask register raw sources.
// - Read-select is a write-only bit 0 of the poll register; writing it alters no interrupt state.
// - The poll read view is read-only: seconds 7, sum 6, ADC 5, ms 4, SPI tx 3, rx/I2C 2, ALV 1, DLV 0.
// - The seconds timer has the lowest auxiliary priority and digital low voltage the highest.
// - The pending register holds a 4-bit index in bits 3-0, upper bits zero, reset value 00h.
// - Index 0 means none, else 1 DLV, 2 ALV, 3 SPI rx/I2C, 4 SPI tx, 5 ms, 6 ADC, 7 sum, 8 seconds.
// - SPI receive and I2C status share one slot, poll bit 2 and one index code.
// - All auxiliary interrupts are taken through the single vector address 0033h.
// - The whole auxiliary group is enabled by bit 4 of the extended control register at D8h.
// - Each source has a mask bit in the register at A6h: 0 masks it and 1 enables it.
// - The status register shows 1 for each active unmasked source and 0 otherwise.
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ns

module aux_interrupt_poll_pending #(
  parameter int AW = aux_irq_pkg::ADDR_W
) (
  // Clock, reset and clock enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // Interrupt sources, one level per slot, from logic on aclk
  input wire logic [aux_irq_pkg::NUM_SRC-1:0] irq_src,
  // Request to the core
  output aux_irq_pkg::irq_out_s irq_out,
  // AXI4-Lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [AW-1:0] awaddr,
  input wire logic [2:0] awprot,
  // AXI4-Lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [aux_irq_pkg::DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [AW-1:0] araddr,
  input wire logic [2:0] arprot,
  // AXI4-Lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [aux_irq_pkg::DATA_W-1:0] rdata,
  output logic [1:0] rresp
);
  import aux_irq_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [NUM_SRC-1:0] mask_reg;
  logic poll_read_select_reg;
  logic aux_en_reg;
  logic [PEND_W-1:0] pend_reg;
  logic [NUM_SRC-1:0] stat_reg;
  irq_out_s irq_reg;
  logic awready_reg;
  logic wready_reg;
  logic aw_full_reg;
  logic w_full_reg;
  logic [AW-1:0] aw_addr_reg;
  logic [REG_W-1:0] w_byte_reg;
  logic w_lane_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [1:0] rresp_reg;

  // ----------------------------------------------------------------
  // Source qualification and priority
  // ----------------------------------------------------------------
  // Sources are levels owned by their peripherals; this block only observes them
  wire [NUM_SRC-1:0] active = irq_src & mask_reg;
  wire any_active = |active;
  wire [PEND_W-1:0] prio_chain [0:NUM_SRC];

  assign prio_chain[NUM_SRC] = PEND_NONE;
  // Bit 0 sits at the head of the chain so it overrides every later slot
  for (genvar g = 0; g < NUM_SRC; g++) begin : g_prio
    localparam logic [PEND_W-1:0] CODE = PEND_W'(g + 1);
    assign prio_chain[g] = active[g] ? CODE : prio_chain[g + 1];
  end
  wire [PEND_W-1:0] pend_next = prio_chain[0];
  wire req_next = aux_en_reg & any_active;

  // ----------------------------------------------------------------
  // Bus handshakes and address decode
  // ----------------------------------------------------------------
  wire aw_hs = awvalid & awready_reg;
  wire w_hs = wvalid & wready_reg;
  wire ar_hs = arvalid & arready_reg;
  wire wr_go = aw_full_reg & w_full_reg & ~bvalid_reg;
  wire wr_poll = aw_addr_reg == ADDR_POLL;
  wire wr_mask = aw_addr_reg == ADDR_MASK;
  wire wr_xctl = aw_addr_reg == ADDR_XCTL;
  wire wr_ro = (aw_addr_reg == ADDR_PEND) | (aw_addr_reg == ADDR_STAT);
  wire wr_hit = wr_poll | wr_mask | wr_xctl | wr_ro;
  wire wr_en = wr_go & w_lane_reg;
  wire rd_hit = (araddr == ADDR_POLL) | (araddr == ADDR_PEND) | (araddr == ADDR_MASK) |
                (araddr == ADDR_STAT) | (araddr == ADDR_XCTL);
  // Read-select swaps the two views of mask and raw sources
  wire [REG_W-1:0] poll_view = poll_read_select_reg ? irq_src : mask_reg;
  wire [REG_W-1:0] mask_view = poll_read_select_reg ? mask_reg : irq_src;
  wire [REG_W-1:0] xctl_view = REG_W'({aux_en_reg, {XCTL_AUX_EN_BIT{1'b0}}});
  wire [REG_W-1:0] rd_byte =
    (araddr == ADDR_POLL) ? poll_view :
    (araddr == ADDR_PEND) ? REG_W'(pend_reg) :
    (araddr == ADDR_MASK) ? mask_view :
    (araddr == ADDR_STAT) ? stat_reg :
    (araddr == ADDR_XCTL) ? xctl_view : 8'h00;
  wire [DATA_W-1:0] rd_word = DATA_W'(rd_byte);

  // ----------------------------------------------------------------
  // Software-visible control
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_reg <= MASK_RST;
      poll_read_select_reg <= POLL_READ_SELECT_RST;
      aux_en_reg <= XCTL_AUX_EN_RST;
    end else if (ce && wr_en) begin
      if (wr_poll) begin
        poll_read_select_reg <= w_byte_reg[POLL_READ_SELECT_BIT];
      end
      if (wr_mask) begin
        mask_reg <= w_byte_reg;
      end
      if (wr_xctl) begin
        aux_en_reg <= w_byte_reg[XCTL_AUX_EN_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // Status, pending index and request
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pend_reg <= PEND_NONE;
      stat_reg <= MASK_RST;
      irq_reg <= '0;
    end else if (ce) begin
      pend_reg <= pend_next;
      stat_reg <= active;
      irq_reg.req <= req_next;
      irq_reg.index <= pend_next;
      irq_reg.vector <= AUX_VECTOR_ADDR;
    end
  end

  // ----------------------------------------------------------------
  // Write channels: address and data latch independently
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b1;
      aw_full_reg <= 1'b0;
      aw_addr_reg <= '0;
    end else if (ce) begin
      if (aw_hs) begin
        aw_addr_reg <= awaddr;
        aw_full_reg <= 1'b1;
        awready_reg <= 1'b0;
      end else if (wr_go) begin
        aw_full_reg <= 1'b0;
      end else if (bvalid_reg && bready) begin
        awready_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_reg <= 1'b1;
      w_full_reg <= 1'b0;
      w_byte_reg <= '0;
      w_lane_reg <= 1'b0;
    end else if (ce) begin
      if (w_hs) begin
        w_byte_reg <= wdata[REG_W-1:0];
        w_lane_reg <= wstrb[0];
        w_full_reg <= 1'b1;
        wready_reg <= 1'b0;
      end else if (wr_go) begin
        w_full_reg <= 1'b0;
      end else if (bvalid_reg && bready) begin
        wready_reg <= 1'b1;
      end
    end
  end

  // Readies stay low until the response is taken, so one write at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else if (ce) begin
      if (wr_go) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_reg && bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read channel: data is a snapshot taken at the address handshake
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= RESP_OKAY;
    end else if (ce) begin
      if (ar_hs) begin
        arready_reg <= 1'b0;
        rvalid_reg <= 1'b1;
        rdata_reg <= rd_word;
        rresp_reg <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_reg && rready) begin
        rvalid_reg <= 1'b0;
        arready_reg <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign irq_out = irq_reg;
  assign awready = awready_reg;
  assign wready = wready_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign arready = arready_reg;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence seq_poll_read;
    ce && ar_hs && araddr == ADDR_POLL;
  endsequence
  sequence seq_mask_read;
    ce && ar_hs && araddr == ADDR_MASK;
  endsequence
  sequence seq_poll_write;
    ce && wr_en && wr_poll;
  endsequence
  sequence seq_write_taken;
    ce && wr_go;
  endsequence

  AST_POLL_RAW_VIEW:
    assert property (seq_poll_read ##0 poll_read_select_reg |=> rdata == DATA_W'($past(irq_src)))
    else $error("poll read with select high did not return raw sources");
  AST_MASK_STORED_VIEW:
    assert property (seq_mask_read ##0 poll_read_select_reg |=> rdata == DATA_W'($past(mask_reg)))
    else $error("mask read with select high did not return stored mask");
  AST_POLL_MASK_VIEW:
    assert property (seq_poll_read ##0 !poll_read_select_reg |=> rdata == DATA_W'($past(mask_reg)))
    else $error("poll read with select low did not return stored mask");
  AST_MASK_RAW_VIEW:
    assert property (seq_mask_read ##0 !poll_read_select_reg |=> rdata == DATA_W'($past(irq_src)))
    else $error("mask read with select low did not return raw sources");
  AST_SELECT_WRITE_ONLY:
    assert property (seq_poll_write |=> poll_read_select_reg == $past(w_byte_reg[POLL_READ_SELECT_BIT])
                     && mask_reg == $past(mask_reg) && aux_en_reg == $past(aux_en_reg))
    else $error("poll write did something other than store the select bit");
  AST_POLL_NOT_WRITABLE:
    assert property (seq_poll_write |=> mask_reg == $past(mask_reg) && stat_reg == $past(active))
    else $error("poll write leaked into the poll read view");
  AST_LOWEST_PRIO_SEC:
    assert property (ce && active == (8'h01 << SRC_SEC) |=> pend_reg == 4'h8)
    else $error("lone seconds source did not give the last index");
  AST_DLV_WINS:
    assert property (ce && active[SRC_DIG_LOW_V] |=> pend_reg == 4'h1 ##0 irq_out.index == 4'h1)
    else $error("digital low voltage did not win the pending index");
  AST_PEND_UPPER_ZERO:
    assert property (ce && ar_hs && araddr == ADDR_PEND |=> rdata[DATA_W-1:PEND_W] == '0
                     && rdata[PEND_W-1:0] == $past(pend_reg))
    else $error("pending read had upper bits set or wrong index");
  AST_NONE_PENDING:
    assert property (ce && !any_active |=> pend_reg == PEND_NONE && !irq_out.req)
    else $error("index or request set with nothing pending");
  AST_SHARED_SLOT:
    assert property (ce && active == (8'h01 << SRC_SPI_RX_I2C) |=> pend_reg == 4'h3)
    else $error("shared receive slot did not give index 3");
  AST_SINGLE_VECTOR:
    assert property (irq_out.req |-> irq_out.vector == 16'h0033)
    else $error("request raised with a vector other than the shared one");
  AST_GROUP_ENABLE:
    assert property (ce |=> irq_out.req == ($past(aux_en_reg) && $past(any_active)))
    else $error("request does not follow group enable and active sources");
  AST_MASK_BLOCKS:
    assert property (ce && wr_en && wr_mask && w_byte_reg == 8'h00 ##1 ce
                     |=> stat_reg == 8'h00 && pend_reg == PEND_NONE)
    else $error("cleared mask still let a source through");
  AST_STATUS_READ:
    assert property (ce && ar_hs && araddr == ADDR_STAT |=> rdata == DATA_W'($past(stat_reg)))
    else $error("status read did not show active unmasked sources");
  AST_HIGHEST_OF_MANY:
    assert property (ce && active[SRC_ADC] && active[SRC_SEC] && active[SRC_MSEC:0] == '0
                     |=> pend_reg == 4'h6)
    else $error("index did not name the highest of several pending sources");
  AST_MASK_WRITE_LANDS:
    assert property (seq_write_taken ##0 (wr_mask && w_lane_reg)
                     |=> mask_reg == $past(w_byte_reg))
    else $error("mask write did not store the written byte");
  AST_LANE_OFF_KEEPS:
    assert property (seq_write_taken ##0 !w_lane_reg
                     |=> $stable(mask_reg) && $stable(poll_read_select_reg) && $stable(aux_en_reg))
    else $error("write with byte lane 0 off changed a control bit");
  AST_READONLY_WRITE:
    assert property (seq_write_taken ##0 wr_ro
                     |=> $stable(mask_reg) && $stable(poll_read_select_reg) && $stable(aux_en_reg))
    else $error("write to a read-only register changed a control bit");
  AST_READ_UPPER_ZERO:
    assert property (rvalid |-> rdata[DATA_W-1:REG_W] == '0)
    else $error("read data carried bits above the register byte");
  AST_GROUP_WRITE_LANDS:
    assert property (seq_write_taken ##0 (wr_xctl && w_lane_reg)
                     |=> aux_en_reg == $past(w_byte_reg[XCTL_AUX_EN_BIT]))
    else $error("extended control write did not store the group enable");
  // Clock enable low must hold every flop, or a stalled core would lose a request
  AST_CE_FREEZE:
    assert property (!ce |=> $stable(stat_reg) && $stable(pend_reg) && $stable(irq_out)
                     && $stable(mask_reg))
    else $error("state moved while the clock enable was low");

endmodule

// File: tb.sv
// Self-checking testbench of the auxiliary interrupt poll and pending block
`timescale 1ns/1ns

module tb;
  import aux_irq_pkg::*;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic ce = 1'b1;
  logic [NUM_SRC-1:0] irq_src = 8'h00;
  irq_out_s irq_out;
  logic awvalid = 1'b0;
  logic awready;
  logic [ADDR_W-1:0] awaddr = 12'h000;
  logic wvalid = 1'b0;
  logic wready;
  logic [DATA_W-1:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic bvalid;
  logic bready = 1'b0;
  logic [1:0] bresp;
  logic arvalid = 1'b0;
  logic arready;
  logic [ADDR_W-1:0] araddr = 12'h000;
  logic rvalid;
  logic rready = 1'b0;
  logic [DATA_W-1:0] rdata;
  logic [1:0] rresp;
  int failures = 0;
  int checks = 0;

  always #4 aclk = ~aclk;

  // Protection bits stay fixed: nothing in this block depends on them
  aux_interrupt_poll_pending uut (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .irq_src(irq_src), .irq_out(irq_out),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp)
  );

  // ----------------------------------------------------------------
  // Reporting
  // ----------------------------------------------------------------
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // ----------------------------------------------------------------
  // Bus and stimulus tasks
  // ----------------------------------------------------------------
  // Leading edge keeps a new request off the edge that released the last one
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s,
                    input logic [1:0] exp_resp);
    int n;
    logic done;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    done = 1'b0;
    while (!done && n < 50) begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        done = 1'b1;
        bready <= 1'b0;
        chk("write response", {30'h0, exp_resp}, {30'h0, bresp});
      end
    end
    if (!done) begin
      failures++;
      $display("[ERR] write answer expected bvalid seen timeout");
      close_out();
    end
  endtask

  task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp,
                        input logic [1:0] exp_resp);
    int n;
    logic done;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    done = 1'b0;
    while (!done && n < 50) begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        done = 1'b1;
        rready <= 1'b0;
        chk(what, exp, rdata);
        chk("read response", {30'h0, exp_resp}, {30'h0, rresp});
      end
    end
    if (!done) begin
      failures++;
      $display("[ERR] read answer expected rvalid seen timeout");
      close_out();
    end
  endtask

  // Sources are registered once inside, so two edges let the change settle
  task automatic set_src(input logic [7:0] v);
    @(posedge aclk);
    irq_src <= v;
    repeat (2) @(posedge aclk);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rd_chk("poll after reset", ADDR_POLL, 32'h0, RESP_OKAY);
    rd_chk("pending after reset", ADDR_PEND, 32'h0, RESP_OKAY);
    rd_chk("status after reset", ADDR_STAT, 32'h0, RESP_OKAY);
    rd_chk("group enable after reset", ADDR_XCTL, 32'h0, RESP_OKAY);
  endtask

  task automatic t_select();
    set_src(8'hC3);
    wr(ADDR_MASK, 8'h5A, 4'hF, RESP_OKAY);
    rd_chk("poll sel0", ADDR_POLL, 32'h5A, RESP_OKAY);
    rd_chk("mask sel0", ADDR_MASK, 32'hC3, RESP_OKAY);
    wr(ADDR_POLL, 8'h01, 4'hF, RESP_OKAY);
    rd_chk("poll sel1", ADDR_POLL, 32'hC3, RESP_OKAY);
    rd_chk("mask sel1", ADDR_MASK, 32'h5A, RESP_OKAY);
    rd_chk("status", ADDR_STAT, 32'h42, RESP_OKAY);
    rd_chk("pending masked", ADDR_PEND, 32'h2, RESP_OKAY);
    // Only bit 0 of a poll write may land: the mask must survive it
    wr(ADDR_POLL, 8'hFE, 4'hF, RESP_OKAY);
    rd_chk("poll back to sel0", ADDR_POLL, 32'h5A, RESP_OKAY);
    rd_chk("status after poll write", ADDR_STAT, 32'h42, RESP_OKAY);
    wr(ADDR_MASK, 8'hFF, 4'hE, RESP_OKAY);
    rd_chk("mask lane0 off", ADDR_POLL, 32'h5A, RESP_OKAY);
  endtask

  task automatic t_priority();
    wr(ADDR_MASK, 8'hFF, 4'hF, RESP_OKAY);
    // The seconds source stays up, so each lower bit must win over it
    for (int i = 0; i < 8; i++) begin
      set_src(8'h80 | (8'h01 << i));
      rd_chk("pending code", ADDR_PEND, 32'(i + 1), RESP_OKAY);
      chk("index out", 32'(i + 1), {28'h0, irq_out.index});
    end
    wr(ADDR_POLL, 8'h01, 4'hF, RESP_OKAY);
    set_src(8'h04);
    rd_chk("shared slot poll", ADDR_POLL, 32'h04, RESP_OKAY);
    rd_chk("shared slot code", ADDR_PEND, 32'h3, RESP_OKAY);
    set_src(8'h00);
    rd_chk("nothing pending", ADDR_PEND, 32'h0, RESP_OKAY);
  endtask

  task automatic t_group();
    set_src(8'h20);
    wr(ADDR_XCTL, 8'hFF, 4'hF, RESP_OKAY);
    rd_chk("group enable bit", ADDR_XCTL, 32'h10, RESP_OKAY);
    chk("request on", 32'h1, {31'h0, irq_out.req});
    chk("vector", 32'h0033, {16'h0, irq_out.vector});
    chk("index on request", 32'h6, {28'h0, irq_out.index});
    wr(ADDR_MASK, 8'h00, 4'hF, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk("request masked", 32'h0, {31'h0, irq_out.req});
    rd_chk("pending masked", ADDR_PEND, 32'h0, RESP_OKAY);
    wr(ADDR_MASK, 8'hFF, 4'hF, RESP_OKAY);
    wr(ADDR_XCTL, 8'h00, 4'hF, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk("request group off", 32'h0, {31'h0, irq_out.req});
    rd_chk("pending group off", ADDR_PEND, 32'h6, RESP_OKAY);
  endtask

  task automatic t_readonly();
    wr(ADDR_PEND, 8'hFF, 4'hF, RESP_OKAY);
    rd_chk("pending kept", ADDR_PEND, 32'h6, RESP_OKAY);
    wr(ADDR_STAT, 8'hFF, 4'hF, RESP_OKAY);
    rd_chk("status kept", ADDR_STAT, 32'h20, RESP_OKAY);
    wr(12'h004, 8'hFF, 4'hF, RESP_SLVERR);
    rd_chk("unmapped", 12'h004, 32'h0, RESP_SLVERR);
  endtask

  // Bus stays idle while the clock enable is low, since it freezes the slave too
  task automatic t_freeze();
    @(posedge aclk);
    ce <= 1'b0;
    irq_src <= 8'h01;
    repeat (3) @(posedge aclk);
    chk("index frozen", 32'h6, {28'h0, irq_out.index});
    ce <= 1'b1;
    repeat (2) @(posedge aclk);
    chk("index after thaw", 32'h1, {28'h0, irq_out.index});
    rd_chk("status after thaw", ADDR_STAT, 32'h01, RESP_OKAY);
  endtask

  task automatic t_rerun();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk("poll after second reset", ADDR_POLL, 32'h0, RESP_OKAY);
    rd_chk("mask view after second reset", ADDR_MASK, 32'h01, RESP_OKAY);
    rd_chk("pending after second reset", ADDR_PEND, 32'h0, RESP_OKAY);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_select();
    t_priority();
    t_group();
    t_readonly();
    t_freeze();
    t_rerun();
    close_out();
  end
endmodule
